/* File: design/soc_pkg.sv */
// Purpose: Shared constants and types for the switchgear object control block.
// Assumes: One object per instance, register port with read data one cycle later.
// Notes: Register offsets are byte addresses of 32-bit words.
package soc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_NAME_IDX = 8'h0C;
  localparam logic [7:0] REG_NAME_DATA = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  // Control register fields.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_SINGLE_IN = 2;
  localparam int CTRL_REMOTE = 3;
  localparam int CTRL_SBO = 4;
  localparam int CTRL_USE_SYNC = 5;
  localparam int CTRL_READY_LSB = 6;
  localparam int CTRL_FORCE_EN = 8;
  localparam int CTRL_FORCE_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0009;
  // Command register fields.
  localparam int CMD_OPEN = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_SELECT = 2;
  // Status register fields.
  localparam int ST_POS_LSB = 0;
  localparam int ST_CART_LSB = 2;
  localparam int ST_OPEN_OK = 5;
  localparam int ST_CLOSE_OK = 6;
  localparam int ST_READY = 7;
  localparam int ST_SYNC = 8;
  localparam int ST_FSTATE_LSB = 12;
  localparam int NAME_LEN = 32;
  localparam int PULSE_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {OT_WD_BREAKER, OT_BREAKER, OT_DISC_MC, OT_DISC_GND} soc_type_e;
  typedef enum logic [1:0] {POS_MID, POS_OPEN, POS_CLOSED, POS_BAD} soc_pos_e;
  typedef enum logic [2:0] {CART_MID, CART_OUT, CART_IN, CART_BAD, CART_UNUSED} soc_cart_e;
  typedef enum logic [1:0] {RDY_OFF, RDY_HIGH, RDY_LOW} soc_ready_e;
endpackage

/* File: design/soc_object_ctrl.sv */
// Purpose: Position decode, command gating and coil drive for one switchgear object.
// Assumes: Contact and push button inputs are asynchronous; automatic requests are on clk.
// Notes: Coil pulses have a fixed length; settings change on any control register write.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module soc_object_ctrl #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0A5A // Arbitrary identity value.
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [soc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic pin_open_pos,
  input wire logic pin_closed_pos,
  input wire logic pin_cart_in,
  input wire logic pin_cart_out,
  input wire logic pin_ready,
  input wire logic pin_sync_ok,
  input wire logic pin_button_open,
  input wire logic pin_button_close,
  input wire logic panel_open,
  input wire logic panel_close,
  input wire logic auto_open,
  input wire logic auto_close,
  output logic coil_open,
  output logic coil_close,
  output logic [1:0] breaker_pos,
  output logic [2:0] cart_pos
);
  localparam int NP = 6;
  logic [NP-1:0] pins;
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;
  logic [NP-1:0] sync3_q;
  assign pins = {pin_button_close, pin_button_open, pin_sync_ok, pin_ready, pin_cart_out, pin_cart_in};
  // Contact inputs pass two flops; a third stage gives button edges.
  // Push buttons act on their rising edge, so a held button gives one command.
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
    end
  endgenerate
  logic [1:0] pos1_q;
  logic [1:0] pos2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos1_q <= 2'h0;
      pos2_q <= 2'h0;
    end else begin
      pos1_q <= {pin_closed_pos, pin_open_pos};
      pos2_q <= pos1_q;
    end
  end

  logic [31:0] ctrl_q;
  logic sel_open_q;
  logic sel_close_q;
  logic [1:0] sel_done_q;
  logic [7:0] name_q [soc_pkg::NAME_LEN];
  logic [4:0] name_idx_q;
  soc_pkg::soc_type_e obj_type;
  soc_pkg::soc_ready_e ready_mode;
  logic single_in;
  logic is_remote;
  logic sbo_mode;
  logic use_sync;
  logic force_en;
  logic [3:0] force_state;
  assign obj_type = soc_pkg::soc_type_e'(ctrl_q[soc_pkg::CTRL_TYPE_LSB +: 2]);
  assign ready_mode = soc_pkg::soc_ready_e'(ctrl_q[soc_pkg::CTRL_READY_LSB +: 2]);
  assign single_in = ctrl_q[soc_pkg::CTRL_SINGLE_IN];
  assign is_remote = ctrl_q[soc_pkg::CTRL_REMOTE];
  assign sbo_mode = ctrl_q[soc_pkg::CTRL_SBO];
  assign use_sync = ctrl_q[soc_pkg::CTRL_USE_SYNC];
  assign force_en = ctrl_q[soc_pkg::CTRL_FORCE_EN];
  assign force_state = ctrl_q[soc_pkg::CTRL_FORCE_LSB +: 4];

  // Position decode from synchronised contacts.
  // In single-input mode the closed contact is ignored and the open level is inverted.
  logic open_in;
  logic closed_in;
  logic cart_in_s;
  logic cart_out_s;
  soc_pkg::soc_pos_e pos_d;
  soc_pkg::soc_cart_e cart_d;
  assign open_in = pos2_q[0];
  assign closed_in = single_in ? ~pos2_q[0] : pos2_q[1];
  assign cart_in_s = sync2_q[0];
  assign cart_out_s = sync2_q[1];
  assign pos_d = (open_in && closed_in) ? soc_pkg::POS_BAD :
                 (!open_in && !closed_in) ? soc_pkg::POS_MID :
                 open_in ? soc_pkg::POS_OPEN : soc_pkg::POS_CLOSED;
  // A type without a cart never looks at its cart contacts.
  assign cart_d = (obj_type != soc_pkg::OT_WD_BREAKER) ? soc_pkg::CART_UNUSED :
                  (cart_in_s && cart_out_s) ? soc_pkg::CART_BAD :
                  (!cart_in_s && !cart_out_s) ? soc_pkg::CART_MID :
                  cart_in_s ? soc_pkg::CART_IN : soc_pkg::CART_OUT;

  // Close interlocks apply only to breaker types.
  logic is_breaker;
  logic ready_ok;
  logic sync_ok;
  logic open_allowed;
  logic close_allowed;
  assign is_breaker = (obj_type == soc_pkg::OT_WD_BREAKER) || (obj_type == soc_pkg::OT_BREAKER);
  assign ready_ok = (ready_mode == soc_pkg::RDY_HIGH) ? sync2_q[2] :
                    (ready_mode == soc_pkg::RDY_LOW) ? ~sync2_q[2] : 1'b1;
  assign sync_ok = use_sync ? sync2_q[3] : 1'b1;
  // An earthing switch is position indication only and never takes a command.
  assign open_allowed = (obj_type != soc_pkg::OT_DISC_GND);
  assign close_allowed = open_allowed && (!is_breaker || (ready_ok && sync_ok));

  // Command sources and local/remote gating.
  logic reg_cmd;
  logic rem_open;
  logic rem_close;
  logic loc_open;
  logic loc_close;
  logic req_open;
  logic req_close;
  assign reg_cmd = wr && (addr == soc_pkg::REG_CMD);
  assign rem_open = reg_cmd && wdata[soc_pkg::CMD_OPEN] && !wdata[soc_pkg::CMD_SELECT] &&
                    (!sbo_mode || sel_open_q);
  assign rem_close = reg_cmd && wdata[soc_pkg::CMD_CLOSE] && !wdata[soc_pkg::CMD_SELECT] &&
                     (!sbo_mode || sel_close_q);
  assign loc_open = panel_open || (sync2_q[4] && !sync3_q[4]);
  assign loc_close = panel_close || (sync2_q[5] && !sync3_q[5]);
  // Automatic requests bypass the local/remote switch; an open beats a close.
  assign req_open = auto_open || (is_remote ? rem_open : loc_open);
  assign req_close = !req_open && (auto_close || (is_remote ? rem_close : loc_close));

  // Register writes; settings are written whenever the control register is written.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= soc_pkg::CTRL_RESET;
      name_idx_q <= 5'h00;
    end else if (wr && addr == soc_pkg::REG_CTRL) begin
      ctrl_q <= wdata;
    end else if (wr && addr == soc_pkg::REG_NAME_IDX) begin
      name_idx_q <= wdata[4:0];
    end
  end
  // The name store has no reset; software fills it during setup.
  always_ff @(posedge clk) begin
    if (wr && addr == soc_pkg::REG_NAME_DATA) begin
      name_q[name_idx_q] <= wdata[7:0];
    end
  end

  // Selection is held until an execute or a new select arrives.
  // Any command write without the select bit clears a pending selection.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_open_q <= 1'b0;
      sel_close_q <= 1'b0;
    end else if (reg_cmd) begin
      sel_open_q <= wdata[soc_pkg::CMD_SELECT] && wdata[soc_pkg::CMD_OPEN];
      sel_close_q <= wdata[soc_pkg::CMD_SELECT] && wdata[soc_pkg::CMD_CLOSE];
    end
  end

  // Coil pulses; an open request cuts a running close.
  logic [7:0] open_cnt_q;
  logic [7:0] close_cnt_q;
  logic do_open;
  logic do_close;
  logic open_busy;
  // A close is blocked while an open pulse still runs, so the two coils never drive together.
  assign open_busy = (open_cnt_q > 8'h01);
  assign do_open = req_open && open_allowed;
  assign do_close = req_close && close_allowed && !open_busy;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      open_cnt_q <= 8'h00;
      close_cnt_q <= 8'h00;
      coil_open <= 1'b0;
      coil_close <= 1'b0;
      sel_done_q <= 2'h0;
    end else begin
      if (do_open) begin
        open_cnt_q <= 8'(soc_pkg::PULSE_CYC);
        close_cnt_q <= 8'h00;
      end else begin
        open_cnt_q <= (open_cnt_q != 8'h00) ? open_cnt_q - 8'h01 : 8'h00;
        if (do_close) begin
          close_cnt_q <= 8'(soc_pkg::PULSE_CYC);
        end else if (close_cnt_q != 8'h00) begin
          close_cnt_q <= close_cnt_q - 8'h01;
        end
      end
      coil_open <= do_open || (open_cnt_q > 8'h01);
      coil_close <= !do_open && (do_close || (close_cnt_q > 8'h01));
      sel_done_q <= {req_close && !close_allowed, req_open && !open_allowed};
    end
  end

  // Status with optional forced value.
  // A refused request shows in the status word one cycle later, for as long as the request is held.
  logic [31:0] status_w;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      breaker_pos <= 2'h0;
      cart_pos <= 3'h0;
    end else begin
      breaker_pos <= pos_d;
      cart_pos <= cart_d;
    end
  end
  assign status_w = {16'h0000, (force_en ? force_state : 4'h0), 1'b0, sel_done_q, sync_ok,
                     ready_ok, close_allowed, open_allowed, cart_pos, breaker_pos};

  // Read data is zero outside the cycle that follows a read strobe.
  logic [31:0] rdata_d;
  assign rdata_d = (addr == soc_pkg::REG_CTRL) ? ctrl_q :
                   (addr == soc_pkg::REG_STATUS) ? status_w :
                   (addr == soc_pkg::REG_NAME_IDX) ? {27'h0, name_idx_q} :
                   (addr == soc_pkg::REG_NAME_DATA) ? {24'h0, name_q[name_idx_q]} :
                   (addr == soc_pkg::REG_CMD) ? {30'h0, sel_close_q, sel_open_q} :
                   (addr == soc_pkg::REG_ID) ? ID_VALUE : 32'h0000_0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rdata_d : 32'h0000_0000;
    end
  end

  // Properties look at the decoded inputs one edge before the registered outputs.
  // Coil checks leave room for a pulse that was already running when the antecedent held.
  sequence s_close_req;
    req_close && close_allowed && !req_open && !open_busy;
  endsequence
  sequence s_open_req;
    req_open && open_allowed;
  endsequence
  chk_bad_position: assert property (@(posedge clk) disable iff (!rstn)
    (open_in && closed_in) |=> breaker_pos == soc_pkg::POS_BAD) else $error("Bad position not reported.");
  chk_mid_position: assert property (@(posedge clk) disable iff (!rstn)
    (!open_in && !closed_in) |=> breaker_pos == soc_pkg::POS_MID) else $error("Mid position missing.");
  chk_open_position: assert property (@(posedge clk) disable iff (!rstn)
    (open_in && !closed_in) |=> breaker_pos == soc_pkg::POS_OPEN) else $error("Open position missing.");
  chk_closed_position: assert property (@(posedge clk) disable iff (!rstn)
    (!open_in && closed_in) |=> breaker_pos == soc_pkg::POS_CLOSED) else $error("Closed position missing.");
  chk_single_input: assert property (@(posedge clk) disable iff (!rstn)
    (single_in && !pos2_q[0]) |=> breaker_pos == soc_pkg::POS_CLOSED)
    else $error("Single input not inverted.");
  chk_cart_unused: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type != soc_pkg::OT_WD_BREAKER) |=> cart_pos == soc_pkg::CART_UNUSED) else $error("Cart not unused.");
  chk_cart_bad: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == soc_pkg::OT_WD_BREAKER && cart_in_s && cart_out_s) |=> cart_pos == soc_pkg::CART_BAD)
    else $error("Cart bad missing.");
  chk_cart_mid: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == soc_pkg::OT_WD_BREAKER && !cart_in_s && !cart_out_s) |=> cart_pos == soc_pkg::CART_MID)
    else $error("Cart mid missing.");
  chk_cart_in: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == soc_pkg::OT_WD_BREAKER && cart_in_s && !cart_out_s) |=> cart_pos == soc_pkg::CART_IN)
    else $error("Cart in missing.");
  chk_cart_out: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == soc_pkg::OT_WD_BREAKER && !cart_in_s && cart_out_s) |=> cart_pos == soc_pkg::CART_OUT)
    else $error("Cart out missing.");
  chk_open_pulse: assert property (@(posedge clk) disable iff (!rstn)
    s_open_req |=> coil_open [*8]) else $error("Open pulse too short.");
  chk_open_end: assert property (@(posedge clk) disable iff (!rstn)
    (open_cnt_q == 8'h01 && !do_open) |=> !coil_open)
    else $error("Open pulse too long.");
  chk_close_pulse: assert property (@(posedge clk) disable iff (!rstn)
    s_close_req |=> coil_close [*2]) else $error("Close pulse too short.");
  chk_sync_block: assert property (@(posedge clk) disable iff (!rstn)
    (is_breaker && use_sync && !sync2_q[3] && close_cnt_q == 8'h00) |=> !coil_close)
    else $error("Close without sync.");
  chk_ready_block: assert property (@(posedge clk) disable iff (!rstn)
    (is_breaker && ready_mode == soc_pkg::RDY_HIGH && !sync2_q[2] && close_cnt_q == 8'h00) |=> !coil_close)
    else $error("Close without ready.");
  chk_local_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (is_remote && panel_open && !auto_open && !rem_open && open_cnt_q == 8'h00) |=> !coil_open)
    else $error("Local open in remote.");
  chk_remote_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (!is_remote && rem_close && !loc_close && !auto_close && close_cnt_q == 8'h00) |=> !coil_close)
    else $error("Remote close in local.");
  chk_remote_exec: assert property (@(posedge clk) disable iff (!rstn)
    (is_remote && rem_open && open_allowed) |=> coil_open)
    else $error("Remote open not executed.");
  chk_sbo_gate: assert property (@(posedge clk) disable iff (!rstn)
    (is_remote && sbo_mode && reg_cmd && !sel_close_q && !auto_close && close_cnt_q == 8'h00) |=> !coil_close)
    else $error("Close without selection.");
  chk_sel_cleared: assert property (@(posedge clk) disable iff (!rstn)
    (reg_cmd && !wdata[soc_pkg::CMD_SELECT]) |=> (!sel_open_q && !sel_close_q))
    else $error("Selection not cleared.");
  chk_local_close: assert property (@(posedge clk) disable iff (!rstn)
    (!is_remote && panel_close && !req_open && close_allowed && !open_busy) |=> coil_close)
    else $error("Panel close not executed.");
  chk_button_open: assert property (@(posedge clk) disable iff (!rstn)
    (!is_remote && sync2_q[4] && !sync3_q[4] && open_allowed) |=> coil_open)
    else $error("Button open not executed.");
  chk_auto_open: assert property (@(posedge clk) disable iff (!rstn)
    (auto_open && open_allowed) |=> coil_open) else $error("Automatic open not executed.");
  chk_auto_close: assert property (@(posedge clk) disable iff (!rstn)
    (auto_close && !req_open && close_allowed && !open_busy) |=> coil_close)
    else $error("Automatic close not executed.");
  chk_refused_close: assert property (@(posedge clk) disable iff (!rstn)
    (req_close && !close_allowed) |=> status_w[10])
    else $error("Refused close not reported.");
  chk_gnd_no_open: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == soc_pkg::OT_DISC_GND && open_cnt_q == 8'h00) |=> !coil_open)
    else $error("Earthing switch opened.");
  chk_coils_exclusive: assert property (@(posedge clk) disable iff (!rstn)
    !(coil_open && coil_close)) else $error("Both coils driven.");
endmodule

/* File: verification/soc_breaker_model.sv */
// Purpose: Breaker auxiliary contacts that follow the coil commands.
// Assumes: Contacts move five cycles after a coil pulse starts.
// Notes: Mode 1 leaves both contacts inactive, mode 2 makes both active.
`timescale 1ns/100ps
module soc_breaker_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic coil_open,
  input wire logic coil_close,
  input wire logic [1:0] mode,
  output logic open_pos,
  output logic closed_pos
);
  logic closed_q;
  logic [2:0] dly_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      closed_q <= 1'b0;
      dly_q <= 3'h0;
    end else if (coil_open || coil_close) begin
      dly_q <= dly_q + 3'h1;
      if (dly_q == 3'h4) closed_q <= coil_close;
    end else begin
      dly_q <= 3'h0;
    end
  end
  assign open_pos = (mode == 2'h2) | ((mode == 2'h0) & !closed_q);
  assign closed_pos = (mode == 2'h2) | ((mode == 2'h0) & closed_q);
endmodule

/* File: verification/switchgear_object_control_tb.sv */
// Purpose: Self-checking bench for the object control block.
// Assumes: Breaker model on the contact side, register port driven here.
// Notes: Coil pulses are counted over a fixed window after each request.
`timescale 1ns/100ps
module switchgear_object_control_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata, v;
  logic [5:0] src = 6'h0;
  logic cin = 1'b0, cout = 1'b0, rdy = 1'b0, snc = 1'b0;
  logic po, pc, co, cc;
  logic [1:0] bpos, bq, mode = 2'h0;
  logic [2:0] cpos, cq;
  logic [7:0] name [32];
  int bad_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  soc_breaker_model brk_u (.clk(clk), .rstn(rstn), .coil_open(co), .coil_close(cc), .mode(mode),
    .open_pos(po), .closed_pos(pc));
  soc_object_ctrl dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_open_pos(po), .pin_closed_pos(pc), .pin_cart_in(cin), .pin_cart_out(cout),
    .pin_ready(rdy), .pin_sync_ok(snc), .pin_button_open(src[4]), .pin_button_close(src[5]),
    .panel_open(src[0]), .panel_close(src[1]), .auto_open(src[2]), .auto_close(src[3]),
    .coil_open(co), .coil_close(cc), .breaker_pos(bpos), .cart_pos(cpos));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  // Lets contacts reach the registered outputs, samples them mid-cycle, ends on a rising edge.
  task automatic settle(output logic [1:0] b, output logic [2:0] c);
    repeat (5) @(posedge clk);
    @(negedge clk);
    b = bpos;
    c = cpos;
    @(posedge clk);
  endtask
  function automatic logic [2:0] cart_exp(input logic [1:0] t, input logic i, input logic o);
    if (t != 2'h0) return soc_pkg::CART_UNUSED;
    return {1'b0, i, o};
  endfunction
  // Raises source s (or writes CMD when s is 6) and counts coil cycles.
  task automatic fire(input int s, input logic [31:0] c, input int eo, input int ec);
    int no, nc;
    no = 0; nc = 0;
    if (s == 6) wr_reg(soc_pkg::REG_CMD, c);
    else begin
      @(posedge clk) src[s] <= 1'b1;
      @(posedge clk) src[3:0] <= 4'h0;
    end
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      no += (co === 1'b1);
      nc += (cc === 1'b1);
      @(posedge clk);
      if (i == 3) src <= 6'h0;
    end
    cmp(no, eo, "open coil cycles");
    cmp(nc, ec, "close coil cycles");
  endtask
  initial begin
    #(100 * 20000);
    bad_count++;
    finish_test();
  end
  initial begin
    logic [1:0] t;
    void'($urandom(32'hD569));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(soc_pkg::REG_CTRL, v); cmp(v, soc_pkg::CTRL_RESET, "ctrl reset");
    rd_reg(soc_pkg::REG_ID, v); cmp(v, 32'h0000_0A5A, "id value");
    rd_reg(8'h20, v); cmp(v, 32'h0, "unmapped read");
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      settle(bq, cq);
      cmp(bq, (m == 0) ? 1 : (m == 1) ? 0 : 3, "breaker pos");
    end
    wr_reg(soc_pkg::REG_CTRL, 32'h0000_000D);
    mode <= 2'h1;
    settle(bq, cq);
    cmp(bq, soc_pkg::POS_CLOSED, "single input closed");
    mode <= 2'h0;
    settle(bq, cq);
    cmp(bq, soc_pkg::POS_OPEN, "single input open");
    repeat (16) begin
      t = $urandom % 4;
      wr_reg(soc_pkg::REG_CTRL, {28'h0, 2'h2, t});
      cin <= $urandom % 2; cout <= $urandom % 2;
      settle(bq, cq);
      cmp(cq, cart_exp(t, cin, cout), "cart pos");
    end
    wr_reg(soc_pkg::REG_CTRL, soc_pkg::CTRL_RESET);
    fire(0, 0, 0, 0);
    fire(4, 0, 0, 0);
    fire(6, 32'h1, 10, 0);
    wr_reg(soc_pkg::REG_CTRL, 32'h1);
    fire(6, 32'h2, 0, 0);
    fire(1, 0, 0, 10);
    fire(4, 0, 10, 0);
    fire(5, 0, 0, 10);
    fire(2, 0, 10, 0);
    wr_reg(soc_pkg::REG_CTRL, 32'h19);
    fire(6, 32'h2, 0, 0);
    wr_reg(soc_pkg::REG_CMD, 32'h6);
    fire(6, 32'h2, 0, 10);
    wr_reg(soc_pkg::REG_CTRL, 32'h29);
    repeat (5) @(posedge clk);
    rd_reg(soc_pkg::REG_STATUS, v); cmp(v[6], 1'b0, "close blocked");
    fire(3, 0, 0, 0);
    snc <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(soc_pkg::REG_STATUS, v); cmp(v[8:6], 3'h7, "sync and close ok");
    fire(3, 0, 0, 10);
    wr_reg(soc_pkg::REG_CTRL, 32'h49);
    fire(3, 0, 0, 0);
    rdy <= 1'b1;
    repeat (5) @(posedge clk);
    fire(3, 0, 0, 10);
    for (int k = 1; k < 13; k++) begin
      wr_reg(soc_pkg::REG_CTRL, 32'h109 | (k << 12));
      rd_reg(soc_pkg::REG_STATUS, v); cmp(v[15:12], k, "forced state");
    end
    for (int i = 0; i < 32; i++) begin
      name[i] = $urandom;
      wr_reg(soc_pkg::REG_NAME_IDX, i);
      wr_reg(soc_pkg::REG_NAME_DATA, {24'h0, name[i]});
    end
    for (int i = 0; i < 32; i++) begin
      wr_reg(soc_pkg::REG_NAME_IDX, i);
      rd_reg(soc_pkg::REG_NAME_DATA, v); cmp(v[7:0], name[i], "name byte");
    end
    finish_test();
  end
endmodule
